// File: tst_tdm_tx.sv
// Transmit slot formatter: places sense and PDM words in TDM output slots.
// Assumes frame_sync is generated by the host in step with serial_bit_clock.
// Operation
// - Keeper off, LSB option 0: last bit full period; option 1: half period.
// - Keeper on: config 0 holds for LSB period, 1 always; LSB half period.
// - One enable bit turns the output keeper on or off; resets off.
// - Unused bits drive zero when fill is 0, high impedance when 1.
// - Three-bit field sets frame start to slot 0 delay; resets to one.
// - Launch on rising edge when polarity is 0, falling when 1.
// - Voltage-sense words go in their six-bit slot when enabled; slot resets 2.
// - Current-sense words go in their six-bit slot when enabled; slot resets 0.
// - Decimated PDM words go in their six-bit slot when enabled; slot resets 4.
// - Frame starts on rising frame sync at polarity 0, falling at 1.
module tst_tdm_tx (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  input  wire logic [tst_pkg::WORD_BITS-1:0] vsense_sample,
  input  wire logic [tst_pkg::WORD_BITS-1:0] isense_sample,
  input  wire logic [tst_pkg::WORD_BITS-1:0] pdm_sample,
  input  wire logic                          sample_valid,
  input  wire logic                          frame_start_polarity,
  input  wire logic                          serial_bit_clock,
  input  wire logic                          frame_sync,
  output logic                               serial_data_output,
  output logic                               serial_data_output_en,
  output logic                               serial_data_output_keep
);
  import tst_pkg::*;

  // ==========================================================
  // Register file (system clock)
  logic [7:0] fmt_reg;
  logic [7:0] vs_reg;
  logic [7:0] is_reg;
  logic [7:0] pdm_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [WORD_BITS-1:0] vs_hold_reg;
  logic [WORD_BITS-1:0] is_hold_reg;
  logic [WORD_BITS-1:0] pdm_hold_reg;
  logic                 tog_reg;
  logic [4:0]           lrst_cnt_reg;

  wire wr_fmt = reg_wr_en & (reg_addr == ADDR_FMT);
  wire wr_vs  = reg_wr_en & (reg_addr == ADDR_VS);
  wire wr_is  = reg_wr_en & (reg_addr == ADDR_IS);
  wire wr_pdm = reg_wr_en & (reg_addr == ADDR_PDM);

  assign rdata_next = (reg_addr == ADDR_FMT) ? fmt_reg :
                      (reg_addr == ADDR_VS)  ? vs_reg  :
                      (reg_addr == ADDR_IS)  ? is_reg  :
                      (reg_addr == ADDR_PDM) ? pdm_reg : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fmt_reg <= RST_FMT;
      vs_reg  <= RST_VS;
      is_reg  <= RST_IS;
      pdm_reg <= RST_PDM;
      rdata_reg <= 8'h00;
      lrst_cnt_reg <= LRST_HOLD;
    end else begin
      if (wr_fmt) fmt_reg <= reg_wdata;
      if (wr_vs)  vs_reg  <= reg_wdata;
      if (wr_is)  is_reg  <= reg_wdata;
      if (wr_pdm) pdm_reg <= reg_wdata;
      rdata_reg <= rdata_next;
      if (lrst_cnt_reg != 5'h00) lrst_cnt_reg <= lrst_cnt_reg - 5'h01;
    end
  end
  assign reg_rdata = rdata_reg;

  // Sample words held stable while the toggle crosses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vs_hold_reg  <= '0;
      is_hold_reg  <= '0;
      pdm_hold_reg <= '0;
      tog_reg      <= 1'b0;
    end else if (sample_valid) begin
      vs_hold_reg  <= vsense_sample;
      is_hold_reg  <= isense_sample;
      pdm_hold_reg <= pdm_sample;
      tog_reg      <= ~tog_reg;
    end
  end

  // ==========================================================
  // Crossings into the bit clock domain
  tst_sync_if #(.W(1))        rst_if ();
  tst_sync_if #(.W(1))        tog_if ();
  tst_sync_if #(.W(CFG_BITS)) cfg_if ();
  logic lrst;

  assign rst_if.d = sys_rst | (lrst_cnt_reg != 5'h00);
  assign tog_if.d = tog_reg;
  assign cfg_if.d = {frame_start_polarity, pdm_reg, is_reg, vs_reg, fmt_reg};
  assign lrst     = rst_if.q;

  tst_sync2 #(.W(1)) u_rst_sync (
    .clk  (serial_bit_clock),
    .rst  (1'b0),
    .port (rst_if.sync)
  );
  tst_sync2 #(.W(1)) u_tog_sync (
    .clk  (serial_bit_clock),
    .rst  (lrst),
    .port (tog_if.sync)
  );
  tst_sync2 #(.W(CFG_BITS)) u_cfg_sync (
    .clk  (serial_bit_clock),
    .rst  (lrst),
    .port (cfg_if.sync)
  );

  // ==========================================================
  // Configuration decode (bit clock)
  wire [7:0] fmt_l    = cfg_if.q[7:0];
  wire [7:0] vs_l     = cfg_if.q[15:8];
  wire [7:0] is_l     = cfg_if.q[23:16];
  wire [7:0] pdm_l    = cfg_if.q[31:24];
  wire       pol_l    = cfg_if.q[32];
  wire       lsb_half = fmt_l[FMT_LSB_HALF];
  wire       keep_cfg = fmt_l[FMT_KEEP_CFG];
  wire       keep_en  = fmt_l[FMT_KEEP_EN];
  wire       fill_hiz = fmt_l[FMT_FILL];
  wire [2:0] offset   = fmt_l[FMT_OFF_MSB:FMT_OFF_LSB];
  wire       fall_l   = fmt_l[FMT_EDGE];

  // ==========================================================
  // Frame and bit position (bit clock, rising edge)
  logic                fs_reg;
  logic                started_reg;
  logic [CNT_BITS-1:0] cnt_reg;
  logic                tog_seen_reg;
  logic [WORD_BITS-1:0] vs_sh_reg;
  logic [WORD_BITS-1:0] is_sh_reg;
  logic [WORD_BITS-1:0] pdm_sh_reg;
  logic [WORD_BITS-1:0] vs_w_reg;
  logic [WORD_BITS-1:0] is_w_reg;
  logic [WORD_BITS-1:0] pdm_w_reg;
  logic                d_p_reg;
  logic                oe_p_reg;
  logic                lsb_p_reg;
  logic                ph_p_reg;

  wire frame_start = pol_l ? (fs_reg & ~frame_sync) : (~fs_reg & frame_sync);
  wire [CNT_BITS-1:0] cnt_inc = (cnt_reg == CNT_MAX) ? CNT_MAX : cnt_reg + 11'h001;
  wire [CNT_BITS-1:0] idx     = frame_start ? 11'h000 : cnt_inc;
  wire [CNT_BITS-1:0] off_ext = {8'h00, offset};
  wire                in_data = idx >= off_ext;
  wire [CNT_BITS-1:0] rel     = idx - off_ext;
  wire [6:0]          slot    = rel[10:4];
  wire [3:0]          bit_idx = rel[3:0];
  wire                live    = (started_reg | frame_start) & in_data;
  wire is_hit  = is_l[SLOT_EN]  & (slot == {1'b0, is_l[SLOT_IDX_MSB:0]});
  wire vs_hit  = vs_l[SLOT_EN]  & (slot == {1'b0, vs_l[SLOT_IDX_MSB:0]});
  wire pdm_hit = pdm_l[SLOT_EN] & (slot == {1'b0, pdm_l[SLOT_IDX_MSB:0]});
  wire used    = live & (is_hit | vs_hit | pdm_hit);
  wire [3:0]  msb_sel = LAST_BIT - bit_idx;
  wire is_bit  = frame_start ? is_sh_reg[msb_sel] : is_w_reg[msb_sel];
  wire vs_bit  = frame_start ? vs_sh_reg[msb_sel] : vs_w_reg[msb_sel];
  wire pdm_bit = frame_start ? pdm_sh_reg[msb_sel] : pdm_w_reg[msb_sel];
  wire word_bit = is_hit ? is_bit : (vs_hit ? vs_bit : pdm_bit);
  wire d_next   = used & word_bit;
  wire oe_next  = used | ~fill_hiz;
  wire lsb_next = used & (bit_idx == LAST_BIT);
  wire tog_new  = tog_if.q != tog_seen_reg;

  always_ff @(posedge serial_bit_clock) begin
    if (lrst) begin
      fs_reg      <= 1'b0;
      started_reg <= 1'b0;
      cnt_reg     <= CNT_MAX;
      ph_p_reg    <= 1'b0;
    end else begin
      fs_reg      <= frame_sync;
      started_reg <= started_reg | frame_start;
      cnt_reg     <= idx;
      ph_p_reg    <= ~ph_p_reg;
    end
  end

  // New samples staged, then taken whole at each frame start
  always_ff @(posedge serial_bit_clock) begin
    if (lrst) begin
      tog_seen_reg <= 1'b0;
      vs_sh_reg    <= '0;
      is_sh_reg    <= '0;
      pdm_sh_reg   <= '0;
      vs_w_reg     <= '0;
      is_w_reg     <= '0;
      pdm_w_reg    <= '0;
    end else begin
      tog_seen_reg <= tog_if.q;
      if (tog_new) begin
        vs_sh_reg  <= vs_hold_reg;
        is_sh_reg  <= is_hold_reg;
        pdm_sh_reg <= pdm_hold_reg;
      end
      if (frame_start) begin
        vs_w_reg  <= vs_sh_reg;
        is_w_reg  <= is_sh_reg;
        pdm_w_reg <= pdm_sh_reg;
      end
    end
  end

  always_ff @(posedge serial_bit_clock) begin
    if (lrst) begin
      d_p_reg   <= 1'b0;
      oe_p_reg  <= 1'b0;
      lsb_p_reg <= 1'b0;
    end else begin
      d_p_reg   <= d_next;
      oe_p_reg  <= oe_next;
      lsb_p_reg <= lsb_next;
    end
  end

  // ==========================================================
  // Falling-edge copy for falling launch and half-period cut
  logic d_n_reg;
  logic oe_n_reg;
  logic lsb_n_reg;
  logic ph_n_reg;

  always_ff @(negedge serial_bit_clock) begin
    if (lrst) begin
      d_n_reg   <= 1'b0;
      oe_n_reg  <= 1'b0;
      lsb_n_reg <= 1'b0;
      ph_n_reg  <= 1'b0;
    end else begin
      d_n_reg   <= d_p_reg;
      oe_n_reg  <= oe_p_reg;
      lsb_n_reg <= lsb_p_reg;
      ph_n_reg  <= ph_p_reg;
    end
  end

  // ==========================================================
  // Output selection
  wire half_lsb = lsb_half | keep_en;
  wire ph_same  = ph_n_reg == ph_p_reg;
  wire cut_p    = half_lsb & lsb_p_reg & ph_same;
  wire cut_n    = half_lsb & lsb_n_reg & ~ph_same;
  wire lsb_sel  = fall_l ? lsb_n_reg : lsb_p_reg;

  assign serial_data_output      = fall_l ? d_n_reg : d_p_reg;
  assign serial_data_output_en   = fall_l ? (oe_n_reg & ~cut_n) : (oe_p_reg & ~cut_p);
  assign serial_data_output_keep = keep_en & (keep_cfg | lsb_sel);

  // ==========================================================
  // Assertions
  property p_reset_values;
    @(posedge sys_clk) $past(sys_rst) & ~sys_rst |->
      fmt_reg == RST_FMT && vs_reg == RST_VS && is_reg == RST_IS && pdm_reg == RST_PDM;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register reset values wrong");
  property p_keeper_always;
    @(posedge serial_bit_clock) disable iff (lrst)
      keep_en & keep_cfg |-> serial_data_output_keep;
  endproperty
  a_keeper_always: assert property (p_keeper_always)
    else $error("keeper not held");

  property p_keeper_off;
    @(posedge serial_bit_clock) disable iff (lrst)
      ~keep_en |-> ~serial_data_output_keep;
  endproperty
  a_keeper_off: assert property (p_keeper_off)
    else $error("keeper active while disabled");

  property p_fill_zero;
    @(posedge serial_bit_clock) disable iff (lrst)
      ~used & ~fill_hiz & $stable(fmt_l) |=> oe_p_reg & ~d_p_reg;
  endproperty
  a_fill_zero: assert property (p_fill_zero)
    else $error("unused bit not driven low");

  property p_fill_hiz;
    @(posedge serial_bit_clock) disable iff (lrst)
      ~used & fill_hiz |=> ~oe_p_reg;
  endproperty
  a_fill_hiz: assert property (p_fill_hiz)
    else $error("unused bit driven");

  property p_slot0_offset;
    @(posedge serial_bit_clock) disable iff (lrst)
      frame_start & (offset == 3'h0) |-> slot == 7'h00 && bit_idx == 4'h0;
  endproperty
  a_slot0_offset: assert property (p_slot0_offset)
    else $error("slot 0 misplaced");

  property p_half_lsb;
    @(posedge serial_bit_clock) disable iff (lrst)
      ~fall_l & half_lsb & lsb_p_reg & $stable(fmt_l) |-> ~serial_data_output_en;
  endproperty
  a_half_lsb: assert property (p_half_lsb)
    else $error("LSB driven past half period");

  property p_full_lsb;
    @(posedge serial_bit_clock) disable iff (lrst)
      ~fall_l & ~half_lsb & lsb_p_reg & oe_p_reg |-> serial_data_output_en;
  endproperty
  a_full_lsb: assert property (p_full_lsb)
    else $error("LSB not driven full period");

  property p_vsense_slot;
    @(posedge serial_bit_clock) disable iff (lrst)
      used & vs_hit & ~is_hit |=> d_p_reg == $past(vs_bit);
  endproperty
  a_vsense_slot: assert property (p_vsense_slot)
    else $error("voltage sense bit wrong");

  property p_isense_slot;
    @(posedge serial_bit_clock) disable iff (lrst)
      used & is_hit |=> d_p_reg == $past(is_bit) && oe_p_reg;
  endproperty
  a_isense_slot: assert property (p_isense_slot)
    else $error("current sense bit wrong");

  property p_pdm_slot;
    @(posedge serial_bit_clock) disable iff (lrst)
      used & pdm_hit & ~is_hit & ~vs_hit |=> d_p_reg == $past(pdm_bit);
  endproperty
  a_pdm_slot: assert property (p_pdm_slot)
    else $error("PDM bit wrong");
endmodule

// File: tst_pkg.sv
// Constants for the transmit slot formatter of the TDM serial output.
// Assumes an 8-bit register port at the printed offsets and 16-bit slots.
package tst_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_FMT = 8'h0e;
  localparam logic [7:0] ADDR_VS  = 8'h0f;
  localparam logic [7:0] ADDR_IS  = 8'h10;
  localparam logic [7:0] ADDR_PDM = 8'h11;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_FMT = 8'h13;
  localparam logic [7:0] RST_VS  = 8'h02;
  localparam logic [7:0] RST_IS  = 8'h00;
  localparam logic [7:0] RST_PDM = 8'h04;
  // ==========================================================
  // Field positions of the output format register
  localparam int FMT_LSB_HALF = 7;
  localparam int FMT_KEEP_CFG = 6;
  localparam int FMT_KEEP_EN  = 5;
  localparam int FMT_FILL     = 4;
  localparam int FMT_OFF_MSB  = 3;
  localparam int FMT_OFF_LSB  = 1;
  localparam int FMT_EDGE     = 0;
  // ==========================================================
  // Field positions of the slot registers
  localparam int SLOT_EN       = 6;
  localparam int SLOT_IDX_MSB  = 5;
  // ==========================================================
  // Frame geometry
  localparam int WORD_BITS = 16;
  localparam int CNT_BITS  = 11;
  localparam logic [CNT_BITS-1:0] CNT_MAX  = 11'h7ff;
  localparam logic [3:0]          LAST_BIT = 4'hf;
  localparam int CFG_BITS  = 33;
  localparam logic [4:0] LRST_HOLD = 5'h18;
endpackage

// File: tst_sync_if.sv
// Carrier for one group of bits that crosses into another clock domain.
// Assumes the source holds d stable long enough for two sampling edges.
interface tst_sync_if #(parameter int W = 1);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport src  (output d);
  modport dst  (input q);
  modport sync (input d, output q);
endinterface

// File: tst_sync2.sv
// Two-flop synchroniser for levels and quasi-static words.
// Assumes multi-bit inputs change rarely and only while unused.
module tst_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  tst_sync_if.sync port
);
  import tst_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= port.d;
      sync_reg <= meta_reg;
    end
  end

  assign port.q = sync_reg;
endmodule

// File: tst_host_model.sv
// Host end of the TDM link: bit clock, frame sync, capture of the output line.
// Assumes 80-bit frames and launch timing as set by the bench per frame.
module tst_host_model (
  output logic        serial_bit_clock,
  output logic        frame_sync,
  output logic        frame_done,
  output logic [79:0] early_bits,
  output logic [79:0] late_bits,
  output logic [79:0] keep_bits,
  input  wire logic   frame_start_polarity,
  input  wire logic   launch_fall,
  input  wire logic   serial_data_output,
  input  wire logic   serial_data_output_en,
  input  wire logic   serial_data_output_keep
);
  timeunit 1ns;
  timeprecision 1ps;
  logic line;
  logic held;
  // Released line floats unless the keeper holds it
  assign line = serial_data_output_en ? serial_data_output :
                (serial_data_output_keep ? held : 1'bz);
  always @(serial_data_output or serial_data_output_en) begin
    if (serial_data_output_en === 1'b1) held = serial_data_output;
  end
  initial begin
    serial_bit_clock = 1'b0;
    frame_sync = 1'b0;
    frame_done = 1'b0;
    held = 1'bx;
  end
  always #16 serial_bit_clock = ~serial_bit_clock;
  // ==========================================================
  // Frames back to back, sync driven at the falling edge half a bit ahead of bit 0
  initial begin
    forever begin
      for (int k = 0; k < 80; k++) begin
        @(negedge serial_bit_clock);
        frame_sync <= (k == 0) ? ~frame_start_polarity : frame_start_polarity;
        @(posedge serial_bit_clock);
        fork
          sample_bit(k);
        join_none
      end
    end
  end
  // Early look in first half of the bit, late look in second half
  task automatic sample_bit(input int j);
    #(launch_fall ? 22 : 6);
    early_bits[j] = line;
    keep_bits[j] = serial_data_output_keep;
    #16;
    late_bits[j] = line;
    if (j == 79) frame_done = ~frame_done;
  endtask
endmodule

// File: tst_tb.sv
// Self-checking bench for the TDM transmit slot formatter.
// Assumes the host model drives the link and captures whole frames.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tst_pkg::*;
  typedef struct packed {
    logic [79:0] e;
    logic [79:0] l;
    logic [79:0] k;
  } tst_frame_t;
  logic        sys_clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [15:0] vsense_sample;
  logic [15:0] isense_sample;
  logic [15:0] pdm_sample;
  logic        sample_valid;
  logic        frame_start_polarity;
  logic        launch_fall;
  logic        serial_bit_clock;
  logic        frame_sync;
  logic        serial_data_output;
  logic        serial_data_output_en;
  logic        serial_data_output_keep;
  logic        frame_done;
  logic [79:0] early_bits;
  logic [79:0] late_bits;
  logic [79:0] keep_bits;
  logic [15:0] seed;
  tst_frame_t  exp_q[$];
  tst_frame_t  want;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  tst_tdm_tx u_tst_tdm_tx (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vsense_sample(vsense_sample),
    .isense_sample(isense_sample), .pdm_sample(pdm_sample), .sample_valid(sample_valid),
    .frame_start_polarity(frame_start_polarity), .serial_bit_clock(serial_bit_clock),
    .frame_sync(frame_sync), .serial_data_output(serial_data_output),
    .serial_data_output_en(serial_data_output_en),
    .serial_data_output_keep(serial_data_output_keep));

  tst_host_model u_tst_host_model (
    .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync), .frame_done(frame_done),
    .early_bits(early_bits), .late_bits(late_bits), .keep_bits(keep_bits),
    .frame_start_polarity(frame_start_polarity), .launch_fall(launch_fall),
    .serial_data_output(serial_data_output), .serial_data_output_en(serial_data_output_en),
    .serial_data_output_keep(serial_data_output_keep));

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // Checking
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(frame_done) begin
    if (exp_q.size() > 0) begin
      want = exp_q.pop_front();
      check(early_bits, want.e);
      check(late_bits, want.l);
      check(keep_bits, want.k);
    end
  end
  // ==========================================================
  // Expected frame worked out from the register settings
  function automatic tst_frame_t build(input logic [7:0] f, v, i, p,
                                       input logic [15:0] wv, wi, wp);
    tst_frame_t r;
    int off;
    int s;
    int b;
    logic dat;
    logic d;
    logic kp;
    logic hold;
    off = int'(f[3:1]);
    hold = 1'bx;
    for (int j = 0; j < 80; j++) begin
      dat = 1'b0;
      d = 1'b0;
      b = 1;
      if (j >= off) begin
        s = (j - off) / 16;
        b = 15 - (j - off) % 16;
        if (i[6] && i[5:0] == s[5:0]) {dat, d} = {1'b1, wi[b]};
        else if (v[6] && v[5:0] == s[5:0]) {dat, d} = {1'b1, wv[b]};
        else if (p[6] && p[5:0] == s[5:0]) {dat, d} = {1'b1, wp[b]};
      end
      kp = f[5] & (f[6] | (dat & (b == 0)));
      if (dat || !f[4]) begin
        r.e[j] = d;
        hold = d;
      end else r.e[j] = kp ? hold : 1'bz;
      r.l[j] = (dat && b == 0 && (f[7] || f[5])) ? (kp ? hold : 1'bz) : r.e[j];
      r.k[j] = kp;
    end
    return r;
  endfunction
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // ==========================================================
  // Register port and scenario tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    #1;
    check({72'h0, reg_rdata}, {72'h0, exp});
  endtask
  task automatic run(input logic [7:0] f, v, i, p, input logic pol);
    logic [15:0] wv;
    logic [15:0] wi;
    logic [15:0] wp;
    wv = rnd();
    wi = rnd();
    wp = rnd();
    @(posedge sys_clk);
    frame_start_polarity <= pol;
    wr(ADDR_FMT, f);
    wr(ADDR_VS, v);
    wr(ADDR_IS, i);
    wr(ADDR_PDM, p);
    launch_fall = f[0];
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    vsense_sample <= wv;
    isense_sample <= wi;
    pdm_sample <= wp;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    // Let config and samples settle over the rest of the current frame and one whole frame
    repeat (2) @(frame_done);
    #1;
    exp_q.push_back(build(f, v, i, p, wv, wi, wp));
    @(frame_done);
    #1;
  endtask
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    vsense_sample = 16'h0000;
    isense_sample = 16'h0000;
    pdm_sample = 16'h0000;
    sample_valid = 1'b0;
    frame_start_polarity = 1'b0;
    launch_fall = 1'b1;
    seed = 16'h225c;
    // Reset for five system clocks; the design stretches it for the link
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_FMT, RST_FMT);
    rd(ADDR_VS, RST_VS);
    rd(ADDR_IS, RST_IS);
    rd(ADDR_PDM, RST_PDM);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h00);
    rd(ADDR_FMT, RST_FMT);
    run(RST_FMT, RST_VS, RST_IS, RST_PDM, 1'b0);
    run(8'h02, 8'h41, 8'h40, 8'h42, 1'b0);
    run(8'h9f, 8'h81, 8'h43, 8'h40, 1'b1);
    rd(ADDR_VS, 8'h81);
    run(8'h36, 8'h42, 8'h00, 8'h7f, 1'b0);
    run(8'h60, 8'h43, 8'h40, 8'h00, 1'b1);
    run(8'h0a, 8'h42, 8'h42, 8'h41, 1'b0);
    run(8'h41, 8'h40, 8'h41, 8'h00, 1'b1);
    if (exp_q.size() != 0) fail_count++;
    give_verdict();
  end
endmodule
